// ---- dmove_pkg.sv ----
// Constants and types for the data-movement instruction decoder
package dmove_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    // Opcode prefixes
    localparam logic [7:0] OP_PTR_LOAD = 8'hee;
    localparam logic [1:0] OP_PTR_LOAD_SUB = 2'h0;
    localparam logic [7:0] OP_SECOND = 8'hf0;
    localparam logic [3:0] OP_SECOND_NIB = 4'hf;
    localparam logic [5:0] OP_FILE_MOVE = 6'h14;
    localparam logic [3:0] OP_REG_MOVE = 4'hc;
    localparam logic [7:0] OP_BANK_LOAD = 8'h01;
    // Field positions
    localparam int POS_DEST = 9;
    localparam int POS_ACC = 8;
    localparam int POS_PSEL = 4;
    // Indexed literal offset threshold for the access bank
    localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
    // Access bank upper half base (addresses 80h..ffh map to f80h..fffh)
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam int NUM_PTRS = 3;

    typedef enum logic [1:0] {
        DST_NONE,
        DST_ACC,
        DST_FILE
    } dest_type;

    // Q1..Q4 phases of one instruction cycle
    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } phase_type;
endpackage : dmove_pkg

// ---- dmove_bus_if.sv ----
// Decoded operation passed from the decoder front end to the executer
`timescale 1ns/1ps
`default_nettype none
interface dmove_bus_if;
    import dmove_pkg::*;
    logic is_ptr;
    logic is_file;
    logic is_reg;
    logic is_bank;
    logic is_second;
    logic [ADDR_W-1:0] file_addr;
    logic indexed;
    logic to_acc;
    modport dec (output is_ptr, is_file, is_reg, is_bank, is_second, file_addr, indexed, to_acc);
    modport exe (input is_ptr, is_file, is_reg, is_bank, is_second, file_addr, indexed, to_acc);
endinterface : dmove_bus_if
`default_nettype wire

// ---- dmove_decode.sv ----
// Combinational opcode decode and file address formation
`timescale 1ns/1ps
`default_nettype none
module dmove_decode
    import dmove_pkg::*;
(
    // Instruction and state
    input wire logic [WORD_W-1:0] i_word,
    input wire logic [3:0] i_bank,
    input wire logic i_ext_en,
    // Decoded fields
    dmove_bus_if.dec bus
);
    wire logic [7:0] f_field = i_word[7:0];
    wire logic acc_bit = i_word[POS_ACC];

    assign bus.is_ptr = (i_word[15:8] == OP_PTR_LOAD) && (i_word[7:6] == OP_PTR_LOAD_SUB);
    assign bus.is_second = (i_word[15:12] == OP_SECOND_NIB);
    assign bus.is_file = (i_word[15:10] == OP_FILE_MOVE);
    assign bus.is_reg = (i_word[15:12] == OP_REG_MOVE);
    assign bus.is_bank = (i_word[15:8] == OP_BANK_LOAD);
    assign bus.to_acc = ~i_word[POS_DEST];
    // Access bank low part may be redirected to indexed mode
    assign bus.indexed = ~acc_bit && i_ext_en && (f_field <= INDEXED_LIMIT);
    // Bank select above the 8-bit field; access bank splits low/high
    assign bus.file_addr = acc_bit ? {i_bank, f_field}
                         : (f_field >= ACCESS_SPLIT) ? {ACCESS_HI_BANK, f_field} : {4'h0, f_field};
endmodule : dmove_decode
`default_nettype wire

// ---- dmove_core.sv ----
// Execution of pointer load, file move, register move and bank select load
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Pointer load is two words over two cycles, pointer bits 11:8 written in cycle one and the low byte in cycle two.
// - File move is one word, one cycle, any location of the 256-byte bank, affecting only N and Z.
// - File move destination bit 0 sends the value to the accumulator, 1 writes it back to the file.
// - Access bit 0 addresses the access bank, 1 uses the bank select register.
// - With access bit 0 and extended set enabled, a file address up to 5Fh uses indexed literal offset mode.
// - Register move is two words, source read in cycle one, destination written in Q4 of cycle two, no flags.
// - Register move source and destination span the full 12-bit data space, the accumulator included; here the accumulator is a separate register outside it.
// - Bank select load writes the literal low nibble and keeps bits 7:4 at zero.
module dmove_core
    import dmove_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Instruction fetch
    input wire logic [WORD_W-1:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic i_ext_en,
    // Data memory read data, valid in Q3
    input wire logic [DATA_W-1:0] i_rdata,
    // Data memory
    output logic [ADDR_W-1:0] o_addr,
    output logic o_rd,
    output logic o_wr,
    output logic [DATA_W-1:0] o_wdata,
    output logic o_indexed,
    // Architectural state
    output logic [DATA_W-1:0] o_acc,
    output logic [DATA_W-1:0] o_bank_sel,
    output logic o_neg,
    output logic o_zero,
    output logic [NUM_PTRS*ADDR_W-1:0] o_ptrs,
    output logic [1:0] o_phase,
    output logic o_busy
);
    dmove_bus_if bus();
    phase_type phase_q;
    logic [WORD_W-1:0] ir_q;
    logic [3:0] bank_q;
    logic [DATA_W-1:0] acc_q, hold_q, wdata_q;
    logic [ADDR_W-1:0] addr_q;
    logic rd_q, wr_q, idx_q, neg_q, zero_q;
    logic second_q, pend_ptr_q, pend_reg_q;
    logic [1:0] psel_q;
    logic [ADDR_W-1:0] ptr_q [NUM_PTRS];
    logic dest_acc_q;

    dmove_decode u_decode (
        .i_word(ir_q),
        .i_bank(bank_q),
        .i_ext_en(i_ext_en),
        .bus(bus)
    );

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return v == '0;
    endfunction : is_zero

    // Source address for the register move is the full 12-bit field
    wire logic [ADDR_W-1:0] full_addr = ir_q[ADDR_W-1:0];
    wire logic in_second = second_q && bus.is_second;
    wire logic first_file = !second_q && bus.is_file;
    wire logic first_reg = !second_q && bus.is_reg;
    wire logic first_ptr = !second_q && bus.is_ptr;
    wire logic first_bank = !second_q && bus.is_bank;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            phase_q <= PH_Q1;
            ir_q <= '0;
            second_q <= 1'b0;
            pend_ptr_q <= 1'b0;
            pend_reg_q <= 1'b0;
        end else if (i_ce) begin
            phase_q <= phase_type'(phase_q + 2'd1);
            // An empty slot decodes as no operation, so a stale word never runs twice
            if (phase_q == PH_Q1) begin
                ir_q <= i_instr_valid ? i_instr : '0;
            end
            if (phase_q == PH_Q4) begin
                // Second word of a two-word op follows the first
                second_q <= (first_ptr || first_reg);
                pend_ptr_q <= first_ptr;
                pend_reg_q <= first_reg;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bank_q <= BANK_RESET;
            acc_q <= '0;
            hold_q <= '0;
            addr_q <= '0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            wdata_q <= '0;
            idx_q <= 1'b0;
            neg_q <= 1'b0;
            zero_q <= 1'b0;
            psel_q <= '0;
            dest_acc_q <= 1'b0;
            for (int i = 0; i < NUM_PTRS; i++) begin
                ptr_q[i] <= '0;
            end
        end else if (i_ce) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            case (phase_q)
                PH_Q2: begin
                    if (first_file) begin
                        addr_q <= bus.file_addr;
                        idx_q <= bus.indexed;
                        rd_q <= 1'b1;
                    end else if (first_reg) begin
                        addr_q <= full_addr;
                        idx_q <= 1'b0;
                        rd_q <= 1'b1;
                    end
                    // Second word of register move: no dummy read
                end
                PH_Q3: begin
                    if (first_file || first_reg) begin
                        hold_q <= i_rdata;
                    end
                end
                PH_Q4: begin
                    if (first_ptr) begin
                        psel_q <= ir_q[POS_PSEL +: 2];
                        if (ir_q[POS_PSEL +: 2] < 2'(NUM_PTRS)) begin
                            ptr_q[ir_q[POS_PSEL +: 2]][11:8] <= ir_q[3:0];
                        end
                    end else if (in_second && pend_ptr_q) begin
                        if (psel_q < 2'(NUM_PTRS)) begin
                            ptr_q[psel_q][7:0] <= ir_q[7:0];
                        end
                    end else if (in_second && pend_reg_q) begin
                        // Destination is the data memory byte at the full 12-bit field; the accumulator is not mapped
                        addr_q <= full_addr;
                        wdata_q <= hold_q;
                        idx_q <= 1'b0;
                        wr_q <= 1'b1;
                    end else if (first_file) begin
                        neg_q <= hold_q[DATA_W-1];
                        zero_q <= is_zero(hold_q);
                        if (bus.to_acc) begin
                            acc_q <= hold_q;
                        end else begin
                            wdata_q <= hold_q;
                            wr_q <= 1'b1;
                        end
                    end else if (first_bank) begin
                        bank_q <= ir_q[3:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    assign o_addr = addr_q;
    assign o_rd = rd_q;
    assign o_wr = wr_q;
    assign o_wdata = wdata_q;
    assign o_indexed = idx_q;
    assign o_acc = acc_q;
    assign o_bank_sel = {4'h0, bank_q};
    assign o_neg = neg_q;
    assign o_zero = zero_q;
    assign o_ptrs = {ptr_q[2], ptr_q[1], ptr_q[0]};
    assign o_phase = phase_q;
    assign o_busy = second_q;
endmodule : dmove_core
`default_nettype wire

// ---- dmove_monitor.sv ----
// Port assertions for the data-movement decoder
`timescale 1ns/1ps
`default_nettype none
module dmove_monitor
    import dmove_pkg::*;
(
    // Watched ports
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [WORD_W-1:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic i_ext_en,
    input wire logic [ADDR_W-1:0] o_addr,
    input wire logic o_rd,
    input wire logic o_wr,
    input wire logic o_indexed,
    input wire logic [DATA_W-1:0] o_bank_sel,
    input wire logic o_neg,
    input wire logic o_zero,
    input wire logic [1:0] o_phase,
    input wire logic o_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic take = o_phase == 2'h0 && i_ce && i_instr_valid && !o_busy;
    sequence s_fm(d, a);
        take && i_instr[15:10] == OP_FILE_MOVE && i_instr[9] == d && i_instr[8] == a;
    endsequence
    sequence s_move;
        take && i_instr[15:12] == OP_REG_MOVE;
    endsequence
    sequence s_no_write;
        !o_wr [*4];
    endsequence
    a_bank_high_zero: assert property (o_bank_sel[7:4] == 4'h0)
        else $error("bank select high bits set");
    a_bank_load_value: assert property (take && i_instr[15:8] == OP_BANK_LOAD |->
        ##4 o_bank_sel[3:0] == $past(i_instr[3:0], 4)) else $error("bank select load wrong");
    a_fm_to_acc: assert property (s_fm(1'b0, 1'b1) |=> s_no_write)
        else $error("file move to accumulator wrote memory");
    a_fm_write_back: assert property (s_fm(1'b1, 1'b0) |-> ##[1:4] o_wr)
        else $error("file move missed write back");
    a_fm_bank_addr: assert property (s_fm(1'b1, 1'b1) |->
        ##[1:3] o_rd && o_addr[11:8] == o_bank_sel[3:0]) else $error("banked address wrong");
    a_fm_index_range: assert property (o_rd && o_indexed |-> i_ext_en && o_addr <= 12'h05f)
        else $error("indexed flag out of range");
    a_move_write_slot: assert property (s_move |=> s_no_write ##[1:4] o_wr)
        else $error("register move write slot wrong");
    a_move_flags_kept: assert property (s_move |=> $stable({o_neg, o_zero}) [*8])
        else $error("register move changed flags");
    a_move_no_dummy: assert property (s_move |-> ##5 !o_rd [*4])
        else $error("register move second cycle read memory");
endmodule : dmove_monitor
bind dmove_core dmove_monitor mon (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_instr(i_instr),
    .i_instr_valid(i_instr_valid),
    .i_ext_en(i_ext_en),
    .o_addr(o_addr),
    .o_rd(o_rd),
    .o_wr(o_wr),
    .o_indexed(o_indexed),
    .o_bank_sel(o_bank_sel),
    .o_neg(o_neg),
    .o_zero(o_zero),
    .o_phase(o_phase),
    .o_busy(o_busy)
);
`default_nettype wire

// ---- dmem_model.sv ----
// Data memory model behind the decoder's strobes
`timescale 1ns/1ps
`default_nettype none
module dmem_model
    import dmove_pkg::*;
(
    // Memory port
    input wire logic i_clk,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [DATA_W-1:0] i_wdata,
    output logic [DATA_W-1:0] o_rdata
);
    logic [DATA_W-1:0] mem [0:4095];
    logic [DATA_W-1:0] pat_q = 8'h5a;
    // Outside a read the bus toggles, so stale data cannot pass for an answer
    assign o_rdata = i_rd ? mem[i_addr] : pat_q;
    always @(posedge i_clk) begin
        pat_q <= ~pat_q;
        if (i_wr) begin
            mem[i_addr] <= i_wdata;
        end
    end
endmodule : dmem_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the data-movement decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
    import dmove_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    logic [WORD_W-1:0] i_instr = 16'h0000;
    logic i_instr_valid = 1'b0;
    logic i_ext_en = 1'b0;
    logic [DATA_W-1:0] i_rdata;
    logic [ADDR_W-1:0] o_addr;
    logic o_rd, o_wr, o_indexed, o_neg, o_zero, o_busy;
    logic [DATA_W-1:0] o_wdata, o_acc, o_bank_sel;
    logic [NUM_PTRS*ADDR_W-1:0] o_ptrs;
    logic [1:0] o_phase;
    int mismatches = 0;
    int samples_checked = 0;
    dmove_core dut (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_instr(i_instr),
        .i_instr_valid(i_instr_valid),
        .i_ext_en(i_ext_en),
        .i_rdata(i_rdata),
        .o_addr(o_addr),
        .o_rd(o_rd),
        .o_wr(o_wr),
        .o_wdata(o_wdata),
        .o_indexed(o_indexed),
        .o_acc(o_acc),
        .o_bank_sel(o_bank_sel),
        .o_neg(o_neg),
        .o_zero(o_zero),
        .o_ptrs(o_ptrs),
        .o_phase(o_phase),
        .o_busy(o_busy)
    );
    dmem_model pm (.i_clk, .i_addr(o_addr), .i_rd(o_rd), .i_wr(o_wr), .i_wdata(o_wdata), .o_rdata(i_rdata));
    always #5 i_clk = ~i_clk;
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    // One word per instruction cycle, offered just before the Q1 edge
    task automatic exec(input logic [WORD_W-1:0] w);
        int n;
        n = 0;
        while (o_phase !== 2'h0 && n < 20) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 20) begin
            mismatches++;
            results();
        end
        i_instr = w;
        i_instr_valid = 1'b1;
        @(negedge i_clk);
        i_instr_valid = 1'b0;
        repeat (3) @(negedge i_clk);
    endtask : exec
    initial begin
        logic [ADDR_W-1:0] k;
        pm.mem[12'h744] = 8'h80;
        pm.mem[12'hf90] = 8'h00;
        pm.mem[12'h733] = 8'h11;
        pm.mem[12'hfff] = 8'h80;
        // Access bank bytes read by the indexed cases, so the flags stay known
        pm.mem[12'h05f] = 8'h00;
        pm.mem[12'h060] = 8'h01;
        repeat (6) @(negedge i_clk);
        i_rst = 1'b0;
        exec(16'h01a7);
        `CHK("bank", 8'h07, o_bank_sel)
        for (int i = 0; i < 3; i++) begin
            k = 12'h3ab + 12'(i) * 12'h111;
            exec({8'hee, 2'b00, 2'(i), k[11:8]});
            `CHK("ptr high", {1'b1, k[11:8]}, {o_busy, o_ptrs[i*12+8 +: 4]})
            exec({8'hf0, k[7:0]});
            `CHK("ptr", {1'b0, k}, {o_busy, o_ptrs[i*12 +: 12]})
        end
        exec(16'h5144);
        `CHK("acc", 11'h280, {o_wr, o_neg, o_zero, o_acc})
        exec(16'h5290);
        `CHK("writeback", 14'h3f90, {o_wr, o_zero, o_addr})
        exec(16'h5333);
        `CHK("bank addr", 13'h1733, {o_wr, o_addr})
        i_ext_en = 1'b1;
        exec(16'h505f);
        `CHK("indexed", 1'b1, o_indexed)
        exec(16'h5060);
        `CHK("not indexed", 1'b0, o_indexed)
        i_ext_en = 1'b0;
        exec(16'h505f);
        `CHK("ext off", 1'b0, o_indexed)
        // Destination 000h stays clear of the program counter and stack top bytes
        exec(16'hcfff);
        exec(16'hf000);
        `CHK("move", 21'h100080, {o_wr, o_addr, o_wdata})
        `CHK("flags", {1'b0, 1'b1}, {o_neg, o_zero})
        // Clock enable low holds the phase and the pending write strobe
        i_ce = 1'b0;
        repeat (3) @(negedge i_clk);
        `CHK("frozen", 3'h1, {o_phase, o_wr})
        i_ce = 1'b1;
        exec(16'h5144);
        `CHK("resumed", 11'h280, {o_wr, o_neg, o_zero, o_acc})
        results();
    end
endmodule : tb_top
`default_nettype wire
